// [vlan_xlate_regs.vh]
`ifndef VLAN_XLATE_REGS_VH
`define VLAN_XLATE_REGS_VH

// VLAN identifier layout and field widths
`define VID_W 12
`define PORT_MSB 11
`define PORT_LSB 8
`define SVC_MSB 7
`define SVC_LSB 0
`define PCP_W 3
`define HANDLE_W 16

// Special identifier and priority values
`define VID_MGMT 12'h0ff
`define VID_UNTAG_SVC 12'h080
`define VID_ZERO 12'h000
`define SVC_UNTAG 8'h80
`define SVC_RESERVED 8'hff
`define SVC_NONE 8'h00
`define PORT_LAN_OUT 4'h0
`define PCP_DEFAULT 3'h0

// Upstream queue word: handle, pcp, tagged flag, vid
`define QW_W 32
`define QW_VID_LSB 0
`define QW_TAG_BIT 12
`define QW_PCP_LSB 13
`define QW_HANDLE_LSB 16

// Upstream queueing
`define NUM_QUEUES 4
`define QUEUE_DEPTH 32
`define QUEUE_AW 5
`define QUEUE_LOWEST 2'h0

`endif

// [frame_fifo.v]
`timescale 1ns/1ps
module frame_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock_in,
  input wire resetn_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign in_ready_out = (count_ff != DEPTH[AW:0]);
  assign out_valid_out = (count_ff != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr_ff];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

  always @(posedge clock_in) begin
    if (!resetn_in) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                     wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                     rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop & ~push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // frame_fifo

// [vlan_port_service_translator.v]
`timescale 1ns/1ps
`include "vlan_xlate_regs.vh"

module vlan_port_service_translator (
  input wire clock_in,
  input wire resetn_in,
  // Upstream: frame descriptors received on LAN ports
  input wire up_in_valid_in,
  output wire up_in_ready_out,
  input wire [3:0] up_in_port_in,
  input wire up_in_tagged_in,
  input wire [2:0] up_in_pcp_in,
  input wire [11:0] up_in_vid_in,
  input wire [15:0] up_in_handle_in,
  output wire up_drop_out,
  // Upstream: scheduled descriptors toward the uplink
  output wire up_out_valid_out,
  input wire up_out_ready_in,
  output wire [1:0] up_out_queue_out,
  output wire [2:0] up_out_pcp_out,
  output wire [11:0] up_out_vid_out,
  output wire [15:0] up_out_handle_out,
  // Downstream: descriptors from the uplink
  input wire dn_in_valid_in,
  output wire dn_in_ready_out,
  input wire dn_in_tagged_in,
  input wire [2:0] dn_in_pcp_in,
  input wire [11:0] dn_in_vid_in,
  input wire [15:0] dn_in_handle_in,
  output wire dn_drop_out,
  // Downstream: descriptors toward a LAN port or management
  output wire dn_out_valid_out,
  input wire dn_out_ready_in,
  output wire dn_out_mgmt_out,
  output wire [3:0] dn_out_port_out,
  output wire dn_out_tagged_out,
  output wire [2:0] dn_out_pcp_out,
  output wire [11:0] dn_out_vid_out,
  output wire [15:0] dn_out_handle_out
);
  localparam Q_SERVE = 1'b0;
  localparam Q_NEXT = 1'b1;

  function [3:0] queue_weight;
    input [1:0] q;
    begin
      queue_weight = 4'h1 << q;
    end
  endfunction

  function [3:0] port_of;
    input [11:0] vid;
    begin
      port_of = vid[`PORT_MSB:`PORT_LSB];
    end
  endfunction

  function [7:0] svc_of;
    input [11:0] vid;
    begin
      svc_of = vid[`SVC_MSB:`SVC_LSB];
    end
  endfunction

  // ---------------- Upstream classification ----------------
  reg up_rdy_ff;
  reg up_stage_valid_ff;
  reg [1:0] up_stage_queue_ff;
  reg [`QW_W-1:0] up_stage_word_ff;
  reg up_drop_ff;
  reg ing_drop;
  reg [11:0] ing_vid;
  reg [2:0] ing_pcp;
  reg [1:0] ing_queue;
  wire up_accept;
  wire up_drain;
  wire nxt_up_stage_valid;
  wire [`NUM_QUEUES-1:0] q_in_ready;
  wire [`NUM_QUEUES-1:0] q_out_valid;
  wire [`QW_W-1:0] q_out_data [0:`NUM_QUEUES-1];
  reg [`NUM_QUEUES-1:0] q_pop;

  assign up_accept = up_in_valid_in & up_rdy_ff;

  always @* begin
    // Checks look only at the received tag flag and identifier
    ing_drop = up_in_tagged_in &&
               (svc_of(up_in_vid_in) == `SVC_RESERVED ||
                up_in_vid_in == `VID_UNTAG_SVC ||
                up_in_vid_in == `VID_MGMT);
    ing_pcp = up_in_pcp_in;
    ing_vid = {up_in_port_in, svc_of(up_in_vid_in)};
    if (!up_in_tagged_in) begin
      ing_vid = {up_in_port_in, `SVC_UNTAG};
      ing_pcp = `PCP_DEFAULT;
    end else if (up_in_vid_in == `VID_ZERO) begin
      ing_vid = {up_in_port_in, `SVC_UNTAG};
      ing_pcp = `PCP_DEFAULT;
    end
    if (!up_in_tagged_in) begin
      ing_queue = `QUEUE_LOWEST;
    end else begin
      ing_queue = ing_vid[`SVC_MSB:`SVC_MSB-1];
    end
  end

  assign up_drain = up_stage_valid_ff & q_in_ready[up_stage_queue_ff];
  assign nxt_up_stage_valid = (up_stage_valid_ff & ~up_drain) |
                              (up_accept & ~ing_drop);

  always @(posedge clock_in) begin
    if (!resetn_in) begin
      up_rdy_ff <= 1'b0;
      up_stage_valid_ff <= 1'b0;
      up_stage_queue_ff <= 2'h0;
      up_stage_word_ff <= {`QW_W{1'b0}};
      up_drop_ff <= 1'b0;
    end else begin
      up_rdy_ff <= ~nxt_up_stage_valid;
      up_stage_valid_ff <= nxt_up_stage_valid;
      up_drop_ff <= up_accept & ing_drop;
      if (up_accept & ~ing_drop) begin
        up_stage_queue_ff <= ing_queue;
        up_stage_word_ff <= {up_in_handle_in, ing_pcp, 1'b1, ing_vid};
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_QUEUES; gi = gi + 1) begin : g_queue
      frame_fifo #(
        .WIDTH(`QW_W),
        .DEPTH(`QUEUE_DEPTH),
        .AW(`QUEUE_AW)
      ) u_fifo (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .in_valid_in(up_stage_valid_ff && up_stage_queue_ff == gi),
        .in_ready_out(q_in_ready[gi]),
        .in_data_in(up_stage_word_ff),
        .out_valid_out(q_out_valid[gi]),
        .out_ready_in(q_pop[gi]),
        .out_data_out(q_out_data[gi])
      );
    end
  endgenerate

  // ---------------- Weighted scheduler ----------------
  reg sched_state_ff;
  reg [1:0] cur_q_ff;
  reg [3:0] served_ff;
  reg up_out_valid_ff;
  reg [1:0] up_out_queue_ff;
  reg [2:0] up_out_pcp_ff;
  reg [11:0] up_out_vid_ff;
  reg [15:0] up_out_handle_ff;
  wire out_free;
  wire take;
  wire [`QW_W-1:0] head;

  assign out_free = ~up_out_valid_ff | up_out_ready_in;
  assign take = (sched_state_ff == Q_SERVE) & out_free & q_out_valid[cur_q_ff];
  assign head = q_out_data[cur_q_ff];

  always @* begin
    q_pop = {`NUM_QUEUES{1'b0}};
    q_pop[cur_q_ff] = take;
  end

  always @(posedge clock_in) begin
    if (!resetn_in) begin
      sched_state_ff <= Q_SERVE;
      cur_q_ff <= 2'h0;
      served_ff <= 4'h0;
      up_out_valid_ff <= 1'b0;
      up_out_queue_ff <= 2'h0;
      up_out_pcp_ff <= 3'h0;
      up_out_vid_ff <= 12'h000;
      up_out_handle_ff <= 16'h0000;
    end else begin
      if (up_out_ready_in) begin
        up_out_valid_ff <= 1'b0;
      end
      if (take) begin
        up_out_valid_ff <= 1'b1;
        up_out_queue_ff <= cur_q_ff;
        up_out_pcp_ff <= head[`QW_PCP_LSB+2:`QW_PCP_LSB];
        up_out_vid_ff <= head[`QW_TAG_BIT-1:`QW_VID_LSB];
        up_out_handle_ff <= head[`QW_W-1:`QW_HANDLE_LSB];
      end
      case (sched_state_ff)
        Q_SERVE: begin
          // Up to weight frames per visit, then move on
          if (take) begin
            if (served_ff + 4'h1 == queue_weight(cur_q_ff)) begin
              sched_state_ff <= Q_NEXT;
            end
            served_ff <= served_ff + 4'h1;
          end else if (!q_out_valid[cur_q_ff]) begin
            sched_state_ff <= Q_NEXT;
          end
        end
        Q_NEXT: begin
          cur_q_ff <= cur_q_ff + 2'h1;
          served_ff <= 4'h0;
          sched_state_ff <= Q_SERVE;
        end
        default: begin
          sched_state_ff <= Q_SERVE;
        end
      endcase
    end
  end

  // ---------------- Downstream classification ----------------
  reg dn_rdy_ff;
  reg dn_out_valid_ff;
  reg dn_out_mgmt_ff;
  reg [3:0] dn_out_port_ff;
  reg dn_out_tagged_ff;
  reg [2:0] dn_out_pcp_ff;
  reg [11:0] dn_out_vid_ff;
  reg [15:0] dn_out_handle_ff;
  reg dn_drop_ff;
  reg eg_drop;
  reg eg_mgmt;
  wire dn_accept;
  wire nxt_dn_out_valid;

  assign dn_accept = dn_in_valid_in & dn_rdy_ff;

  always @* begin
    eg_mgmt = dn_in_tagged_in && dn_in_vid_in == `VID_MGMT;
    eg_drop = 1'b0;
    if (!dn_in_tagged_in) begin
      eg_drop = 1'b1;
    end else if (!eg_mgmt) begin
      if (svc_of(dn_in_vid_in) == `SVC_RESERVED &&
          port_of(dn_in_vid_in) != `PORT_LAN_OUT) begin
        eg_drop = 1'b1;
      end
      if (svc_of(dn_in_vid_in) == `SVC_NONE) begin
        eg_drop = 1'b1;
      end
    end
  end

  assign nxt_dn_out_valid = (dn_out_valid_ff & ~dn_out_ready_in) |
                            (dn_accept & ~eg_drop);

  always @(posedge clock_in) begin
    if (!resetn_in) begin
      dn_rdy_ff <= 1'b0;
      dn_out_valid_ff <= 1'b0;
      dn_out_mgmt_ff <= 1'b0;
      dn_out_port_ff <= 4'h0;
      dn_out_tagged_ff <= 1'b0;
      dn_out_pcp_ff <= 3'h0;
      dn_out_vid_ff <= 12'h000;
      dn_out_handle_ff <= 16'h0000;
      dn_drop_ff <= 1'b0;
    end else begin
      dn_rdy_ff <= ~nxt_dn_out_valid;
      dn_out_valid_ff <= nxt_dn_out_valid;
      dn_drop_ff <= dn_accept & eg_drop;
      if (dn_accept & ~eg_drop) begin
        dn_out_mgmt_ff <= eg_mgmt;
        dn_out_port_ff <= port_of(dn_in_vid_in);
        dn_out_pcp_ff <= dn_in_pcp_in;
        dn_out_handle_ff <= dn_in_handle_in;
        if (eg_mgmt) begin
          dn_out_tagged_ff <= 1'b1;
          dn_out_vid_ff <= dn_in_vid_in;
        end else begin
          dn_out_vid_ff <= {`PORT_LAN_OUT, svc_of(dn_in_vid_in)};
          dn_out_tagged_ff <= (svc_of(dn_in_vid_in) != `SVC_UNTAG);
        end
      end
    end
  end

  assign up_in_ready_out = up_rdy_ff;
  assign up_drop_out = up_drop_ff;
  assign up_out_valid_out = up_out_valid_ff;
  assign up_out_queue_out = up_out_queue_ff;
  assign up_out_pcp_out = up_out_pcp_ff;
  assign up_out_vid_out = up_out_vid_ff;
  assign up_out_handle_out = up_out_handle_ff;
  assign dn_in_ready_out = dn_rdy_ff;
  assign dn_drop_out = dn_drop_ff;
  assign dn_out_valid_out = dn_out_valid_ff;
  assign dn_out_mgmt_out = dn_out_mgmt_ff;
  assign dn_out_port_out = dn_out_port_ff;
  assign dn_out_tagged_out = dn_out_tagged_ff;
  assign dn_out_pcp_out = dn_out_pcp_ff;
  assign dn_out_vid_out = dn_out_vid_ff;
  assign dn_out_handle_out = dn_out_handle_ff;
endmodule // vlan_port_service_translator

// [vlan_xlate_checker_properties.sv]
`timescale 1ns/1ps
module vlan_xlate_checker (
  input wire clock_in,
  input wire resetn_in,
  input wire dn_in_valid_in,
  input wire dn_in_ready_out,
  input wire dn_in_tagged_in,
  input wire [11:0] dn_in_vid_in,
  input wire dn_drop_out,
  input wire dn_out_valid_out,
  input wire dn_out_mgmt_out,
  input wire dn_out_tagged_out,
  input wire [11:0] dn_out_vid_out,
  input wire up_in_valid_in,
  input wire up_in_ready_out,
  input wire up_in_tagged_in,
  input wire [11:0] up_in_vid_in,
  input wire up_drop_out,
  input wire up_out_valid_out,
  input wire up_out_ready_in,
  input wire [1:0] up_out_queue_out,
  input wire [11:0] up_out_vid_out,
  input wire [15:0] up_out_handle_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  wire dn_take = dn_in_valid_in && dn_in_ready_out && dn_in_tagged_in;
  wire up_take = up_in_valid_in && up_in_ready_out && up_in_tagged_in;
  wire dn_lan = dn_out_valid_out && !dn_out_mgmt_out;
  mgmt_fwd_a: assert property (
    dn_take && dn_in_vid_in == 12'h0ff |=> dn_out_valid_out && dn_out_mgmt_out)
    else $error("mgmt frame not forwarded");
  dn_bad_svc_a: assert property (
    dn_take && dn_in_vid_in[7:0] == 8'hff && dn_in_vid_in[11:8] != 4'h0
    |=> dn_drop_out && !dn_out_valid_out) else $error("svc 255 kept");
  dn_no_svc_a: assert property (
    dn_take && dn_in_vid_in[7:0] == 8'h00 |=> dn_drop_out && !dn_out_valid_out)
    else $error("svc 0 kept");
  lan_port_zero_a: assert property (
    dn_lan |-> dn_out_vid_out[11:8] == 4'h0) else $error("port bits set");
  untag_svc_a: assert property (
    dn_lan |-> dn_out_tagged_out == (dn_out_vid_out[7:0] != 8'h80))
    else $error("tag state wrong");
  up_svc_ff_a: assert property (
    up_take && up_in_vid_in[7:0] == 8'hff |=> up_drop_out)
    else $error("ingress svc 255 kept");
  up_svc_128_a: assert property (
    up_take && up_in_vid_in == 12'h080 |=> up_drop_out)
    else $error("ingress vid 128 kept");
  queue_block_a: assert property (
    up_out_valid_out && up_out_vid_out[7:0] != 8'h80
    |-> up_out_queue_out == up_out_vid_out[7:6]) else $error("wrong queue");
  up_hold_a: assert property (
    up_out_valid_out && !up_out_ready_in |=> up_out_valid_out
    && $stable(up_out_handle_out)) else $error("output not held");
  cover property (dn_take && dn_in_vid_in == 12'h0ff);
  cover property (up_out_valid_out && up_out_queue_out == 2'h3);
  cover property (up_in_valid_in && !up_in_ready_out);
endmodule // vlan_xlate_checker

bind vlan_port_service_translator vlan_xlate_checker u_chk (
  .clock_in, .resetn_in, .dn_in_valid_in, .dn_in_ready_out, .dn_in_tagged_in,
  .dn_in_vid_in, .dn_drop_out, .dn_out_valid_out, .dn_out_mgmt_out,
  .dn_out_tagged_out, .dn_out_vid_out, .up_in_valid_in, .up_in_ready_out,
  .up_in_tagged_in, .up_in_vid_in, .up_drop_out, .up_out_valid_out,
  .up_out_ready_in, .up_out_queue_out, .up_out_vid_out, .up_out_handle_out);

// [lan_far_end.sv]
`timescale 1ns/1ps
module lan_far_end (
  input wire clock_in,
  input wire [1:0] mode_in,
  output reg up_ready_out,
  output reg dn_ready_out
);
  reg [1:0] cnt_ff;
  initial begin
    cnt_ff = 2'h0;
    up_ready_out = 1'b0;
    dn_ready_out = 1'b0;
  end
  // Mode 0 prompt, 1 uplink takes one in four, 2 both sinks hold
  always @(posedge clock_in) begin
    cnt_ff <= cnt_ff + 2'h1;
    up_ready_out <= mode_in == 2'h0 || (mode_in == 2'h1 && cnt_ff == 2'h3);
    dn_ready_out <= mode_in != 2'h2;
  end
endmodule // lan_far_end

// [test_vlan_port_service_translator.sv]
`timescale 1ns/1ps
module test_vlan_port_service_translator;
  reg clock_in = 1'b0;
  reg resetn_in = 1'b0;
  reg up_in_valid_in = 1'b0;
  reg up_in_tagged_in = 1'b0;
  reg [3:0] up_in_port_in = 4'h0;
  reg [2:0] up_in_pcp_in = 3'h0;
  reg [11:0] up_in_vid_in = 12'h000;
  reg [15:0] up_in_handle_in = 16'h0000;
  reg dn_in_valid_in = 1'b0;
  reg dn_in_tagged_in = 1'b0;
  reg [2:0] dn_in_pcp_in = 3'h0;
  reg [11:0] dn_in_vid_in = 12'h000;
  reg [15:0] dn_in_handle_in = 16'h0000;
  reg [1:0] mode = 2'h0;
  reg dn_untag = 1'b0;
  wire up_in_ready_out, up_drop_out, up_out_valid_out, up_out_ready_in;
  wire dn_in_ready_out, dn_drop_out, dn_out_valid_out, dn_out_ready_in;
  wire dn_out_mgmt_out, dn_out_tagged_out;
  wire [1:0] up_out_queue_out;
  wire [2:0] up_out_pcp_out, dn_out_pcp_out;
  wire [3:0] dn_out_port_out;
  wire [11:0] up_out_vid_out, dn_out_vid_out;
  wire [15:0] up_out_handle_out, dn_out_handle_out;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer k, n, c, tk;
  integer run, best;
  always #12.5 clock_in = ~clock_in;
  vlan_port_service_translator u_dut (.clock_in, .resetn_in,
    .up_in_valid_in, .up_in_ready_out, .up_in_port_in, .up_in_tagged_in,
    .up_in_pcp_in, .up_in_vid_in, .up_in_handle_in, .up_drop_out,
    .up_out_valid_out, .up_out_ready_in, .up_out_queue_out, .up_out_pcp_out,
    .up_out_vid_out, .up_out_handle_out, .dn_in_valid_in, .dn_in_ready_out,
    .dn_in_tagged_in, .dn_in_pcp_in, .dn_in_vid_in, .dn_in_handle_in,
    .dn_drop_out, .dn_out_valid_out, .dn_out_ready_in, .dn_out_mgmt_out,
    .dn_out_port_out, .dn_out_tagged_out, .dn_out_pcp_out, .dn_out_vid_out,
    .dn_out_handle_out);
  lan_far_end u_far (.clock_in, .mode_in(mode),
    .up_ready_out(up_out_ready_in), .dn_ready_out(dn_out_ready_in));
  task chk(input [15:0] g, input [15:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task dn_case(input [11:0] v, input [2:0] p, input dr, input mg,
    input [3:0] pt, input tg, input [11:0] ov);
    begin
      dn_in_valid_in <= 1'b1;
      dn_in_tagged_in <= ~dn_untag;
      dn_in_vid_in <= v;
      dn_in_pcp_in <= p;
      dn_in_handle_in <= {4'h0, v};
      k = 0;
      @(posedge clock_in);
      while (dn_in_ready_out !== 1'b1 && k < 50) begin
        k = k + 1;
        @(posedge clock_in);
      end
      dn_in_valid_in <= 1'b0;
      @(negedge clock_in);
      chk(dn_drop_out, dr);
      chk(dn_out_valid_out, !dr);
      if (!dr) begin
        chk(dn_out_mgmt_out, mg);
        chk(dn_out_port_out, pt);
        chk(dn_out_tagged_out, tg);
        chk(dn_out_vid_out, ov);
        chk(dn_out_pcp_out, p);
        chk(dn_out_handle_out, {4'h0, v});
      end
      @(posedge clock_in);
    end
  endtask
  task up_put(input [3:0] pt, input tg, input [2:0] p, input [11:0] v,
    input [15:0] h);
    begin
      up_in_valid_in <= 1'b1;
      up_in_port_in <= pt;
      up_in_tagged_in <= tg;
      up_in_pcp_in <= p;
      up_in_vid_in <= v;
      up_in_handle_in <= h;
      k = 0;
      @(posedge clock_in);
      while (up_in_ready_out !== 1'b1 && k < 40) begin
        k = k + 1;
        @(posedge clock_in);
      end
      tk = up_in_ready_out === 1'b1;
      up_in_valid_in <= 1'b0;
    end
  endtask
  task up_case(input [3:0] pt, input tg, input [2:0] p, input [11:0] v,
    input dr, input [1:0] q, input [11:0] ov, input [2:0] op);
    begin
      up_put(pt, tg, p, v, {pt, v});
      @(negedge clock_in);
      chk(up_drop_out, dr);
      c = 0;
      k = 0;
      while (!dr && !c && k < 300) begin
        @(posedge clock_in);
        c = up_out_valid_out === 1'b1 && up_out_ready_in === 1'b1;
        k = k + 1;
      end
      if (dr)
        @(posedge clock_in);
      else begin
        chk(c, 1);
        chk(up_out_queue_out, q);
        chk(up_out_vid_out, ov);
        chk(up_out_pcp_out, op);
        chk(up_out_handle_out, {pt, v});
      end
    end
  endtask
  task t_down;
    begin
      dn_case(12'h3ff, 3'h1, 1, 0, 4'h0, 0, 12'h000);
      dn_case(12'h0ff, 3'h2, 0, 1, 4'h0, 1, 12'h0ff);
      dn_case(12'h500, 3'h0, 1, 0, 4'h0, 0, 12'h000);
      dn_case(12'h280, 3'h3, 0, 0, 4'h2, 0, 12'h080);
      dn_case(12'ha41, 3'h6, 0, 0, 4'ha, 1, 12'h041);
      $display("downstream test done");
    end
  endtask
  task t_up;
    begin
      up_case(4'h3, 0, 3'h5, 12'h123, 0, 2'h0, 12'h380, 3'h0);
      up_case(4'h5, 1, 3'h6, 12'h000, 0, 2'h2, 12'h580, 3'h0);
      up_case(4'h7, 1, 3'h4, 12'hc41, 0, 2'h1, 12'h741, 3'h4);
      up_case(4'h1, 1, 3'h2, 12'h0c5, 0, 2'h3, 12'h1c5, 3'h2);
      up_case(4'h1, 1, 3'h2, 12'h02a, 0, 2'h0, 12'h12a, 3'h2);
      up_case(4'h2, 1, 3'h0, 12'h3ff, 1, 2'h0, 12'h000, 3'h0);
      up_case(4'h2, 1, 3'h0, 12'h080, 1, 2'h0, 12'h000, 3'h0);
      $display("upstream test done");
    end
  endtask
  task t_slow;
    begin
      mode <= 2'h1;
      up_case(4'h4, 1, 3'h7, 12'h9c3, 0, 2'h3, 12'h4c3, 3'h7);
      up_case(4'hf, 0, 3'h1, 12'h000, 0, 2'h0, 12'hf80, 3'h0);
      mode <= 2'h0;
      $display("slow sink test done");
    end
  endtask
  task t_fill;
    begin
      @(posedge clock_in);
      mode <= 2'h2;
      n = 0;
      tk = 1;
      while (tk && n < 40) begin
        up_put(4'h1, 1'b0, 3'h0, 12'h000, n[15:0]);
        n = n + tk;
        @(posedge clock_in);
      end
      chk(n >= 32 && !tk, 1);
      mode <= 2'h0;
      c = 0;
      k = 0;
      while (c < n && k < 2000) begin
        @(posedge clock_in);
        c = c + (up_out_valid_out === 1'b1 && up_out_ready_in === 1'b1);
        k = k + 1;
      end
      chk(c, n);
      $display("queue fill test done");
    end
  endtask
  // Queue 0 and queue 3 loaded behind a stalled sink, then released
  task t_weight;
    begin
      mode <= 2'h2;
      for (n = 0; n < 24; n = n + 1) begin
        up_put(4'h6, n >= 8, 3'h1, 12'h0c0, n[15:0]);
        @(posedge clock_in);
      end
      mode <= 2'h0;
      c = 0;
      k = 0;
      run = 0;
      best = 0;
      while (c < 24 && k < 500) begin
        @(posedge clock_in);
        if (up_out_valid_out === 1'b1 && up_out_ready_in === 1'b1) begin
          c = c + 1;
          run = (up_out_queue_out === 2'h3) ? run + 1 : 0;
          if (run > best)
            best = run;
        end
        k = k + 1;
      end
      chk(c, 24);
      chk(best, 8);
      $display("weight test done");
    end
  endtask
  task t_dn_hold;
    begin
      mode <= 2'h2;
      dn_case(12'h312, 3'h5, 0, 0, 4'h3, 1, 12'h012);
      repeat (3) @(posedge clock_in);
      @(negedge clock_in);
      chk(dn_out_valid_out, 1'b1);
      chk(dn_in_ready_out, 1'b0);
      chk(dn_out_vid_out, 12'h012);
      @(posedge clock_in);
      mode <= 2'h0;
      dn_untag = 1'b1;
      dn_case(12'h245, 3'h1, 1, 0, 4'h0, 0, 12'h000);
      dn_untag = 1'b0;
      $display("downstream hold test done");
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock_in);
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_down;
    t_up;
    t_slow;
    t_fill;
    t_weight;
    t_dn_hold;
    print_verdict;
  end
endmodule // test_vlan_port_service_translator
